//--- logic/sbi_pkg.sv
// shared constants and types for the split-port burst-of-two memory link
package sbi_pkg;
   // x18 variant widths; the x36 variant would use 36/19/4
   localparam int DATA_W  = 18;
   localparam int ADDR_W  = 20;
   localparam int LANES   = 2;
   localparam int LANE_W  = 9;
   localparam int BURST   = 2;
   // model depth kept small; upper address bits are ignored by the array
   localparam int MEM_AW  = 6;
   localparam int MEM_DEP = 64;
   // controller-side buffer
   localparam int BUF_DEP = 2;
   // read latency: request phase, array phase, first beat
   localparam int RD_LAT  = 2;
   localparam logic [ADDR_W-1:0] ADDR_RST = 20'h0_0000;
   localparam logic [DATA_W-1:0] DATA_RST = 18'h0_0000;
   localparam logic [LANES-1:0]  BWS_OFF  = 2'h3;

   typedef logic [DATA_W-1:0] sbi_word_type;
   typedef logic [ADDR_W-1:0] sbi_addr_type;
   typedef logic [LANES-1:0]  sbi_bws_type;
endpackage

//--- logic/sbi_link_if.sv
// pin-level link between memory controller and memory device
interface sbi_link_if;
   import sbi_pkg::*;
   logic         writePortSelN;
   logic         readPortSelN;
   sbi_addr_type addr;
   sbi_word_type wrData;
   sbi_bws_type  byteWriteSelN;
   logic         wrHalf;
   sbi_word_type rdData;
   logic         rdDataOe;
   logic         rdHalf;
   logic         singleClk;

   modport ctrl (
      output writePortSelN, readPortSelN, addr, wrData, byteWriteSelN, wrHalf, singleClk,
      input  rdData, rdDataOe, rdHalf
   );
   modport dev (
      input  writePortSelN, readPortSelN, addr, wrData, byteWriteSelN, wrHalf, singleClk,
      output rdData, rdDataOe, rdHalf
   );
endinterface

//--- logic/sbi_device.sv
// memory device end: dual-phase write capture, burst-of-two reads
//
// The system clock stands for the input clock pair. wrHalf low marks the
// positive-edge phase, high marks the negative-edge phase; each access is
// one positive phase plus one negative phase, two clock cycles.
//
// What this block does
// - capture write data on both phases
// - write select low at positive phase starts write
// - each byte select gates one nine-bit lane
// - deselected lanes leave memory byte unchanged
// - byte selects sampled with each data word
// - read address positive phase, write address negative
// - address width per variant, two internal arrays
// - address ignored when its port deselected
// - read data driven on both output phases
// - read outputs float while read port deselected and no beats pending
// - read select low at positive phase starts read
// - finish pending read, then float outputs
// - every read returns two sequential words unless the next read starts two cycles later
// - controller supplies output timing reference
// - accesses start only at positive phase
module sbi_device (
   // clock and reset
   input  wire logic clock,
   input  wire logic rst_n,
   // link
   sbi_link_if.dev   link
);
   import sbi_pkg::*;

   typedef struct packed {
      logic         wrAct;
      sbi_addr_type wrAddr;
      sbi_word_type wrD0;
      sbi_bws_type  wrB0;
      logic         rdAct;
      sbi_addr_type rdAddr;
      logic [1:0]   rdBeat;
      sbi_word_type rdData;
      logic         rdOe;
      logic         rdHalf;
   } sbi_dev_state_type;

   sbi_dev_state_type st_r;
   sbi_dev_state_type st_nxt;
   // two internal arrays, one per burst word; stored per lane below
   sbi_word_type      rdEven;
   sbi_word_type      rdOdd;
   logic              wrEven;
   logic              wrOdd;
   logic [MEM_AW-1:0] wrIdx;
   sbi_word_type      wrWord0;
   sbi_word_type      wrWord1;
   sbi_bws_type       wrBws1;

   always_comb begin
      st_nxt = st_r;
      wrEven = 1'b0;
      wrOdd  = 1'b0;
      wrIdx  = st_r.wrAddr[MEM_AW-1:0];
      wrWord0 = st_r.wrD0;
      wrWord1 = link.wrData;
      wrBws1  = link.byteWriteSelN;
      if (!link.wrHalf) begin
         // positive phase: accesses begin only here
         st_nxt.wrAct = !link.writePortSelN;
         if (!link.writePortSelN) begin
            st_nxt.wrD0 = link.wrData;
            st_nxt.wrB0 = link.byteWriteSelN;
         end
         if (!link.readPortSelN) begin
            st_nxt.rdAct  = 1'b1;
            st_nxt.rdAddr = link.addr;
         end else begin
            st_nxt.rdAct = 1'b0;
         end
      end else begin
         // negative phase: write address and second data word
         if (st_r.wrAct) begin
            st_nxt.wrAddr = link.addr;
            wrIdx  = link.addr[MEM_AW-1:0];
            wrEven = 1'b1;
            wrOdd  = 1'b1;
         end
         st_nxt.wrAct = 1'b0;
         if (st_r.rdAct) begin
            st_nxt.rdBeat = 2'd2;
         end
         st_nxt.rdAct = 1'b0;
      end
      // read output pipeline; beats run to completion before floating
      st_nxt.rdHalf = link.wrHalf;
      if (st_r.rdBeat != 2'd0 && !link.wrHalf) begin
         st_nxt.rdData = (st_r.rdBeat == 2'd2) ? rdEven : rdOdd;
         st_nxt.rdOe   = 1'b1;
         st_nxt.rdBeat = st_r.rdBeat - 2'd1;
      end else if (st_r.rdBeat == 2'd1) begin
         st_nxt.rdData = rdOdd;
         st_nxt.rdOe   = 1'b1;
         st_nxt.rdBeat = 2'd0;
      end else if (st_r.rdBeat == 2'd0) begin
         st_nxt.rdOe = 1'b0;
      end
      if (!rst_n) begin
         st_nxt = '{wrAct: 1'b0, wrAddr: ADDR_RST, wrD0: DATA_RST, wrB0: BWS_OFF,
                    rdAct: 1'b0, rdAddr: ADDR_RST, rdBeat: 2'd0, rdData: DATA_RST,
                    rdOe: 1'b0, rdHalf: 1'b0};
         wrEven = 1'b0;
         wrOdd  = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      st_r <= st_nxt;
   end

   // lane-gated array writes; deselected lanes keep old contents
   // two arrays per lane (even and odd word) so each lane has a single writing process
   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : gLane
         logic [LANE_W-1:0] laneEven [MEM_DEP];
         logic [LANE_W-1:0] laneOdd  [MEM_DEP];
         always_ff @(posedge clock) begin
            if (wrEven && !st_r.wrB0[g]) begin
               laneEven[wrIdx] <= wrWord0[g*LANE_W +: LANE_W];
            end
            if (wrOdd && !wrBws1[g]) begin
               laneOdd[wrIdx] <= wrWord1[g*LANE_W +: LANE_W];
            end
         end
         assign rdEven[g*LANE_W +: LANE_W] = laneEven[st_r.rdAddr[MEM_AW-1:0]];
         assign rdOdd[g*LANE_W +: LANE_W]  = laneOdd[st_r.rdAddr[MEM_AW-1:0]];
      end
   endgenerate

   // output timing reference comes from the controller phase
   assign link.rdData   = st_r.rdData;
   assign link.rdDataOe = st_r.rdOe;
   assign link.rdHalf   = st_r.rdHalf;
endmodule

//--- logic/sbi_ctrl.sv
// memory controller end: issues accesses, buffers returned read words
module sbi_ctrl (
   // clock and reset
   input  wire logic             clock,
   input  wire logic             rst_n,
   // user requests, taken on positive phase only
   input  wire logic             wrReq,
   input  wire sbi_pkg::sbi_addr_type wrAddr,
   input  wire sbi_pkg::sbi_word_type wrData0,
   input  wire sbi_pkg::sbi_word_type wrData1,
   input  wire sbi_pkg::sbi_bws_type  wrBwsN0,
   input  wire sbi_pkg::sbi_bws_type  wrBwsN1,
   input  wire logic             rdReq,
   input  wire sbi_pkg::sbi_addr_type rdAddr,
   input  wire logic             singleClkMode,
   output logic                  reqReady,
   // read data stream
   output logic                  rdValid,
   output sbi_pkg::sbi_word_type rdWord,
   input  wire logic             rdReady,
   // link
   sbi_link_if.ctrl              link
);
   import sbi_pkg::*;

   typedef struct packed {
      logic         half;
      logic         wrPend;
      sbi_addr_type wrAddr;
      sbi_word_type wrD1;
      sbi_bws_type  wrB1;
      logic [1:0]   rdOut;
      logic [1:0]   bufCnt;
      logic         bufHead;
      sbi_word_type buf0;
      sbi_word_type buf1;
   } sbi_ctrl_state_type;

   sbi_ctrl_state_type st_r;
   sbi_ctrl_state_type st_nxt;
   logic               take;
   logic               push;
   logic               pop;
   logic               bufTail;

   // issue only when the buffer can absorb a whole burst
   assign reqReady = !st_r.half && (st_r.rdOut + st_r.bufCnt == 2'd0);
   assign take     = reqReady && rdReq;
   assign push     = link.rdDataOe;
   assign pop      = rdValid && rdReady;
   assign rdValid  = st_r.bufCnt != 2'd0;
   assign rdWord   = st_r.bufHead ? st_r.buf1 : st_r.buf0;
   assign bufTail  = st_r.bufHead ^ (st_r.bufCnt == 2'd1);

   always_comb begin
      st_nxt = st_r;
      st_nxt.half = !st_r.half;
      if (!st_r.half) begin
         st_nxt.wrPend = wrReq && reqReady;
         st_nxt.wrAddr = wrAddr;
         st_nxt.wrD1   = wrData1;
         st_nxt.wrB1   = wrBwsN1;
         if (take) begin
            st_nxt.rdOut = 2'd2;
         end
      end
      if (push) begin
         if (bufTail) st_nxt.buf1 = link.rdData;
         else         st_nxt.buf0 = link.rdData;
         st_nxt.rdOut = st_r.rdOut - 2'd1;
      end
      if (pop) st_nxt.bufHead = !st_r.bufHead;
      st_nxt.bufCnt = st_r.bufCnt + {1'b0, push} - {1'b0, pop};
      if (!rst_n) begin
         st_nxt = '{half: 1'b0, wrPend: 1'b0, wrAddr: ADDR_RST, wrD1: DATA_RST,
                    wrB1: BWS_OFF, rdOut: 2'd0, bufCnt: 2'd0, bufHead: 1'b0,
                    buf0: DATA_RST, buf1: DATA_RST};
      end
   end

   always_ff @(posedge clock) begin
      st_r <= st_nxt;
   end

   always_comb begin
      link.wrHalf    = st_r.half;
      link.singleClk = singleClkMode;
      if (!st_r.half) begin
         link.writePortSelN = !(wrReq && reqReady && rst_n);
         link.readPortSelN  = !(take && rst_n);
         link.addr          = rdAddr;
         link.wrData        = wrData0;
         link.byteWriteSelN = wrBwsN0;
      end else begin
         link.writePortSelN = 1'b1;
         link.readPortSelN  = 1'b1;
         link.addr          = st_r.wrAddr;
         link.wrData        = st_r.wrD1;
         link.byteWriteSelN = st_r.wrPend ? st_r.wrB1 : BWS_OFF;
      end
   end
endmodule

//--- test/sbi_link_checker.sv
// concurrent checks on the link between controller and device
module sbi_link_checker (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // link
   input wire logic writePortSelN,
   input wire logic readPortSelN,
   input wire logic wrHalf,
   input wire logic rdDataOe,
   input wire logic singleClk
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);

   logic rdStart;
   assign rdStart = !readPortSelN && !wrHalf;

   sequence rdBurst;
      rdDataOe ##1 rdDataOe;
   endsequence
   sequence phasePair;
      wrHalf ##1 !wrHalf;
   endsequence

   chk_wr_phase: assert property (!writePortSelN |-> !wrHalf)
      else $error("write select outside positive phase");
   chk_rd_phase: assert property (!readPortSelN |-> !wrHalf)
      else $error("read select outside positive phase");
   chk_rd_burst: assert property (rdStart |-> ##3 rdBurst)
      else $error("read burst not two beats at fixed latency");
   chk_oe_cause: assert property (rdDataOe |-> $past(rdStart, 3) || $past(rdStart, 4))
      else $error("read outputs driven without a read");
   chk_oe_release: assert property (rdStart ##2 readPortSelN |-> ##3 !rdDataOe)
      else $error("read outputs not released after burst");
   chk_rd_spacing: assert property (rdStart |=> readPortSelN)
      else $error("read select held into negative phase");
   chk_wr_spacing: assert property (!writePortSelN |=> writePortSelN)
      else $error("write select held into negative phase");
   chk_phase_walk: assert property (rdStart |=> phasePair)
      else $error("phase does not alternate after read");
   chk_mode_static: assert property (rdDataOe |-> $stable(singleClk))
      else $error("clock mode changed during read");
endmodule

//--- test/tb.sv
// self-checking bench: controller and device joined by the link
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import sbi_pkg::*;

   logic         clock, rst_n, wrReq, rdReq, rdReady, reqReady, rdValid;
   sbi_addr_type wrAddr, rdAddr;
   sbi_word_type wrData0, wrData1, rdWord;
   sbi_bws_type  wrBwsN0, wrBwsN1;
   int           bad_count = 0;
   int           checks_done = 0;

   sbi_link_if link ();
   sbi_ctrl i_sbi_ctrl (.clock(clock), .rst_n(rst_n), .wrReq(wrReq), .wrAddr(wrAddr),
      .wrData0(wrData0), .wrData1(wrData1), .wrBwsN0(wrBwsN0), .wrBwsN1(wrBwsN1),
      .rdReq(rdReq), .rdAddr(rdAddr), .singleClkMode(1'b0), .reqReady(reqReady),
      .rdValid(rdValid), .rdWord(rdWord), .rdReady(rdReady), .link(link));
   sbi_device i_sbi_device (.clock(clock), .rst_n(rst_n), .link(link));
   sbi_link_checker i_sbi_link_checker (.clock(clock), .rst_n(rst_n),
      .writePortSelN(link.writePortSelN), .readPortSelN(link.readPortSelN),
      .wrHalf(link.wrHalf), .rdDataOe(link.rdDataOe), .singleClk(link.singleClk));

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   task automatic check(input sbi_word_type got, input sbi_word_type exp, input string what);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // request held one cycle only: holding longer would be taken twice
   task automatic issue(input logic w, input logic r);
      int n;
      n = 0;
      while (reqReady !== 1'b1 && n < 50) begin
         @(negedge clock);
         n++;
      end
      wrReq = w;
      rdReq = r;
      @(negedge clock);
      wrReq = 1'b0;
      rdReq = 1'b0;
      if (w) begin
         check(sbi_word_type'(link.wrHalf), 18'h0_0001, "negative phase");
         check(sbi_word_type'(link.addr), sbi_word_type'(wrAddr), "write address");
         check(link.wrData, wrData1, "second write word");
         check(sbi_word_type'(link.byteWriteSelN), sbi_word_type'(wrBwsN1), "lanes");
      end
   endtask

   task automatic wr(input sbi_addr_type a, input sbi_word_type d0, d1,
                     input sbi_bws_type b0, b1);
      wrAddr = a;
      wrData0 = d0;
      wrData1 = d1;
      wrBwsN0 = b0;
      wrBwsN1 = b1;
   endtask

   task automatic rd(input sbi_addr_type a, input sbi_word_type e0, e1, input int stall,
                     input logic w);
      int n;
      n = 0;
      rdAddr = a;
      issue(w, 1'b1);
      while (rdValid !== 1'b1 && n < 20) begin
         @(negedge clock);
         n++;
      end
      repeat (stall) @(negedge clock);
      check(sbi_word_type'(reqReady), '0, "ready while words held");
      check(rdWord, e0, "first beat");
      rdReady = 1'b1;
      @(negedge clock);
      check(rdWord, e1, "second beat");
      @(negedge clock);
      rdReady = 1'b0;
      check(sbi_word_type'(rdValid), '0, "valid after both pops");
      check(sbi_word_type'(link.rdDataOe), '0, "outputs float when idle");
   endtask

   task automatic t_lanes;
      wr(20'h0_0006, 18'h0_5A5A, 18'h1_A5A5, 2'h0, 2'h0);
      issue(1'b1, 1'b0);
      rd(20'h0_0006, 18'h0_5A5A, 18'h1_A5A5, 0, 1'b0);
      wr(20'h0_0006, 18'h3_FFFF, 18'h3_FFFF, 2'h2, 2'h1);
      issue(1'b1, 1'b0);
      rd(20'h0_0006, {9'h02D, 9'h1FF}, {9'h1FF, 9'h1A5}, 0, 1'b0);
      wr(20'h0_0006, 18'h0_0000, 18'h0_0000, BWS_OFF, BWS_OFF);
      issue(1'b1, 1'b0);
      rd(20'h0_0006, {9'h02D, 9'h1FF}, {9'h1FF, 9'h1A5}, 0, 1'b0);
      $display("test lanes done");
   endtask

   task automatic t_both;
      wr(20'h0_0008, 18'h1_1111, 18'h2_2222, 2'h0, 2'h0);
      issue(1'b1, 1'b0);
      wr(20'h0_000A, 18'h3_0303, 18'h0_4040, 2'h0, 2'h0);
      rd(20'h0_0008, 18'h1_1111, 18'h2_2222, 0, 1'b1);
      rd(20'h0_000A, 18'h3_0303, 18'h0_4040, 0, 1'b0);
      $display("test both ports done");
   endtask

   task automatic t_stall;
      rd(20'h0_0008, 18'h1_1111, 18'h2_2222, 6, 1'b0);
      $display("test stall done");
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial begin
      #(5 * 2000);
      bad_count++;
      test_done();
   end

   initial begin
      rst_n = 1'b0;
      wrReq = 1'b0;
      rdReq = 1'b0;
      rdReady = 1'b0;
      wr(20'h0_0000, 18'h0_0000, 18'h0_0000, BWS_OFF, BWS_OFF);
      rdAddr = 20'h0_0000;
      repeat (8) @(negedge clock);
      rst_n = 1'b1;
      t_lanes();
      t_both();
      t_stall();
      test_done();
   end
endmodule
